//--- rcsl_pkg.sv
// constants and types for the reset cause and state logic
package rcsl_pkg;
  // reset delay timer, nominal figure and core clock rate
  localparam int DRT_TIME_MS  = 18;
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int DRT_CYCLES   = DRT_TIME_MS * CLK_FREQ_KHZ;

  // register indices, byte address is four times the index
  localparam logic [3:0] IDX_IDW    = 4'h0;
  localparam logic [3:0] IDX_TMR    = 4'h1;
  localparam logic [3:0] IDX_PCL    = 4'h2;
  localparam logic [3:0] IDX_STATUS = 4'h3;
  localparam logic [3:0] IDX_PTR    = 4'h4;
  localparam logic [3:0] IDX_FIRST_PORT_LATCH  = 4'h5;
  localparam logic [3:0] IDX_SECOND_PORT_LATCH  = 4'h6;
  localparam logic [3:0] IDX_THIRD_PORT_LATCH  = 4'h7;
  localparam logic [3:0] IDX_ACC    = 4'h8;
  localparam logic [3:0] IDX_DIR    = 4'h9;
  localparam logic [3:0] IDX_OPT    = 4'ha;
  localparam logic [3:0] IDX_EVT    = 4'hb;
  localparam logic [3:0] IDX_MASK   = 4'hc;
  localparam logic [3:0] IDX_STATE  = 4'hd;

  // processor status fields
  localparam int STS_TO = 4;
  localparam int STS_PD = 3;
  localparam logic [2:0] STS_PAGE_RST = 3'h0;

  // reset values
  localparam logic [7:0] PCL_RST       = 8'hff;
  localparam logic [7:0] DIR_RST       = 8'hff;
  localparam logic [5:0] OPT_RST       = 6'h3f;
  localparam logic [7:0] PTR_SET_LARGE = 8'h80;
  localparam logic [7:0] PTR_SET_SMALL = 8'he0;

  // flag pairs {timeout_flag, powerdown_flag}
  localparam logic [1:0] FL_POR      = 2'h3;
  localparam logic [1:0] FL_PIN_WAKE = 2'h2;
  localparam logic [1:0] FL_WDT_RUN  = 2'h1;
  localparam logic [1:0] FL_WDT_WAKE = 2'h0;

  // cause event bits
  localparam int EV_POR      = 0;
  localparam int EV_PIN_RUN  = 1;
  localparam int EV_PIN_WAKE = 2;
  localparam int EV_WDT_RUN  = 3;
  localparam int EV_WDT_WAKE = 4;
  localparam int EV_N        = 5;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_TIMING} rcsl_state_t;
endpackage

//--- rcsl_top.sv
// reset cause and state logic with an axi4-lite register view
//
// Overview of operation
// - five reset causes: power-on, pin run, pin wake, watchdog run, watchdog wake.
// - pin or watchdog wake-up from halt gives a full reset, no resume.
// - retained registers are undefined after power-on, kept through other resets.
// - timeout and powerdown flags sit at status bits 4 and 3.
// - flags: power-on 11, pin run kept, pin wake 10, watchdog run 01, wake 00.
// - status page bits clear on reset; power-on 0001 1xxx, else 000q quuu.
// - direction, pc low byte and six-bit options load all ones on any reset.
// - pointer top bit set on reset, top three bits on small variant.
// - accumulator, window, timer, ports, file keep values through non-power-on reset.
// - delay timer starts only once pin is high, then releases reset.
// - watchdog time-out starts delay timer; core held while it runs.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module rcsl_top #(
  parameter int DRT_CYCLES = rcsl_pkg::DRT_CYCLES,
  parameter bit SMALL_PTR  = 1'b0
) (
  input  wire logic        aclk,          // core clock
  input  wire logic        aresetn,       // power-on reset, active low
  input  wire logic        ext_reset_n,   // external reset pin
  input  wire logic        wdt_timeout,   // watchdog time-out pulse
  input  wire logic        sleep_active,  // core is in low-power halt
  output logic             core_reset,    // core held in reset
  output logic             irq,           // unmasked cause event
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready   // read data ready
);
  localparam int CW = $clog2(DRT_CYCLES + 1);
  localparam logic [CW-1:0] DRT_LAST = CW'(DRT_CYCLES - 1);
  localparam logic [7:0] PTR_SET =
    SMALL_PTR ? rcsl_pkg::PTR_SET_SMALL : rcsl_pkg::PTR_SET_LARGE;

  // refuse a timer the counter cannot serve
  if (DRT_CYCLES < 1) begin : g_chk
    $error("DRT_CYCLES must be at least 1");
  end

  typedef struct packed {
    rcsl_pkg::rcsl_state_t state;
    logic [2:0]              pin_sync;
    logic                    pin_lvl;
    logic [CW-1:0]           drt_cnt;
    logic                    core_rst;
    logic [7:0]              idw;
    logic [7:0]              tmr;
    logic [7:0]              pc_low_byte;
    logic [7:0]              status;
    logic [7:0]              ptr;
    logic [3:0]              first_port_latch;
    logic [7:0]              second_port_latch;
    logic [7:0]              third_port_latch;
    logic [7:0]              acc;
    logic [7:0]              dir;
    logic [5:0]              opt;
    logic [4:0]              evt;
    logic [4:0]              mask;
    logic                    irq;
    logic                    aw_got;
    logic [7:0]              aw_addr;
    logic                    w_got;
    logic [7:0]              w_data;
    logic                    w_lane;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [7:0]              rdata;
    logic [1:0]              rresp;
  } rcsl_regs_t;

  rcsl_regs_t st_r;
  rcsl_regs_t st_nxt;
  logic       wr_en;
  logic [3:0] wr_idx;
  logic       wr_ok;
  logic [3:0] rd_idx;
  logic       rd_ok;
  logic [7:0] rd_val;
  logic [4:0] ev_set;
  logic [1:0] flags;

  // register read mux
  always_comb begin
    rd_idx = s_axi_araddr[5:2];
    rd_ok  = (s_axi_araddr[7:6] == 2'h0) && (rd_idx <= rcsl_pkg::IDX_STATE);
    unique case (rd_idx)
      rcsl_pkg::IDX_IDW:    rd_val = st_r.idw;
      rcsl_pkg::IDX_TMR:    rd_val = st_r.tmr;
      rcsl_pkg::IDX_PCL:    rd_val = st_r.pc_low_byte;
      rcsl_pkg::IDX_STATUS: rd_val = st_r.status;
      rcsl_pkg::IDX_PTR:    rd_val = st_r.ptr;
      rcsl_pkg::IDX_FIRST_PORT_LATCH:  rd_val = {4'h0, st_r.first_port_latch};
      rcsl_pkg::IDX_SECOND_PORT_LATCH:  rd_val = st_r.second_port_latch;
      rcsl_pkg::IDX_THIRD_PORT_LATCH:  rd_val = st_r.third_port_latch;
      rcsl_pkg::IDX_ACC:    rd_val = st_r.acc;
      rcsl_pkg::IDX_DIR:    rd_val = st_r.dir;
      rcsl_pkg::IDX_OPT:    rd_val = {2'h0, st_r.opt};
      rcsl_pkg::IDX_EVT:    rd_val = {3'h0, st_r.evt};
      rcsl_pkg::IDX_MASK:   rd_val = {3'h0, st_r.mask};
      rcsl_pkg::IDX_STATE:  rd_val = {6'h0, st_r.pin_lvl, st_r.core_rst};
      default:              rd_val = 8'h00;
    endcase
  end

  // next state of everything
  always_comb begin
    st_nxt = st_r;
    ev_set = 5'h00;
    flags  = st_r.status[rcsl_pkg::STS_TO:rcsl_pkg::STS_PD];
    wr_idx = st_r.aw_addr[5:2];
    wr_ok  = (st_r.aw_addr[7:6] == 2'h0) && (wr_idx <= rcsl_pkg::IDX_STATE);
    wr_en  = st_r.aw_got && st_r.w_got && !st_r.bvalid;

    // pin filter: second and third stage must agree
    st_nxt.pin_sync = {st_r.pin_sync[1:0], ext_reset_n};
    if (st_r.pin_sync[1] == st_r.pin_sync[2]) begin
      st_nxt.pin_lvl = st_r.pin_sync[2];
    end

    // reset sequencer
    unique case (st_r.state)
      rcsl_pkg::ST_RUN: begin
        if (!st_r.pin_lvl) begin
          st_nxt.state = rcsl_pkg::ST_HOLD;
          if (sleep_active) begin
            flags = rcsl_pkg::FL_PIN_WAKE;
            ev_set[rcsl_pkg::EV_PIN_WAKE] = 1'b1;
          end else begin
            ev_set[rcsl_pkg::EV_PIN_RUN] = 1'b1;
          end
        end else if (wdt_timeout) begin
          st_nxt.state   = rcsl_pkg::ST_TIMING;
          st_nxt.drt_cnt = '0;
          if (sleep_active) begin
            flags = rcsl_pkg::FL_WDT_WAKE;
            ev_set[rcsl_pkg::EV_WDT_WAKE] = 1'b1;
          end else begin
            flags = rcsl_pkg::FL_WDT_RUN;
            ev_set[rcsl_pkg::EV_WDT_RUN] = 1'b1;
          end
        end
      end
      rcsl_pkg::ST_HOLD: begin
        if (st_r.pin_lvl) begin
          st_nxt.state   = rcsl_pkg::ST_TIMING;
          st_nxt.drt_cnt = '0;
        end
      end
      rcsl_pkg::ST_TIMING: begin
        if (!st_r.pin_lvl) begin
          st_nxt.state = rcsl_pkg::ST_HOLD;
        end else if (st_r.drt_cnt == DRT_LAST) begin
          st_nxt.state = rcsl_pkg::ST_RUN;
        end else begin
          st_nxt.drt_cnt = st_r.drt_cnt + CW'(1);
        end
      end
    endcase

    // write channel acceptance, either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got  = 1'b1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got  = 1'b1;
      st_nxt.w_data = s_axi_wdata[7:0];
      st_nxt.w_lane = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // register writes, low byte lane only
    if (wr_en) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = wr_ok ? rcsl_pkg::RESP_OKAY : rcsl_pkg::RESP_SLVERR;
      if (wr_ok && st_r.w_lane) begin
        unique case (wr_idx)
          rcsl_pkg::IDX_IDW:    st_nxt.idw = st_r.w_data;
          rcsl_pkg::IDX_TMR:    st_nxt.tmr = st_r.w_data;
          rcsl_pkg::IDX_PCL:    st_nxt.pc_low_byte = st_r.w_data;
          rcsl_pkg::IDX_STATUS: begin
            st_nxt.status[7:5] = st_r.w_data[7:5];
            st_nxt.status[2:0] = st_r.w_data[2:0];
          end
          rcsl_pkg::IDX_PTR:    st_nxt.ptr   = st_r.w_data;
          rcsl_pkg::IDX_FIRST_PORT_LATCH:  st_nxt.first_port_latch = st_r.w_data[3:0];
          rcsl_pkg::IDX_SECOND_PORT_LATCH:  st_nxt.second_port_latch = st_r.w_data;
          rcsl_pkg::IDX_THIRD_PORT_LATCH:  st_nxt.third_port_latch = st_r.w_data;
          rcsl_pkg::IDX_ACC:    st_nxt.acc   = st_r.w_data;
          rcsl_pkg::IDX_DIR:    st_nxt.dir   = st_r.w_data;
          rcsl_pkg::IDX_OPT:    st_nxt.opt   = st_r.w_data[5:0];
          rcsl_pkg::IDX_MASK:   st_nxt.mask  = st_r.w_data[4:0];
          default: ;
        endcase
      end
    end

    // event bits: set wins over write-one-to-clear
    if (wr_en && wr_ok && st_r.w_lane && wr_idx == rcsl_pkg::IDX_EVT) begin
      st_nxt.evt = st_r.evt & ~st_r.w_data[4:0];
    end
    st_nxt.evt = st_nxt.evt | ev_set;
    st_nxt.irq = |(st_nxt.evt & st_nxt.mask);

    // read channel
    if (s_axi_rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = rd_ok ? rd_val : 8'h00;
      st_nxt.rresp  = rd_ok ? rcsl_pkg::RESP_OKAY : rcsl_pkg::RESP_SLVERR;
    end

    // flags written only at reset entry, kept otherwise
    st_nxt.status[rcsl_pkg::STS_TO:rcsl_pkg::STS_PD] = flags;

    // reset values held while the core is in reset
    st_nxt.core_rst = (st_nxt.state != rcsl_pkg::ST_RUN);
    if (st_nxt.core_rst) begin
      st_nxt.pc_low_byte         = rcsl_pkg::PCL_RST;
      st_nxt.dir         = rcsl_pkg::DIR_RST;
      st_nxt.opt         = rcsl_pkg::OPT_RST;
      st_nxt.status[7:5] = rcsl_pkg::STS_PAGE_RST;
      st_nxt.ptr         = st_nxt.ptr | PTR_SET;
    end

    // power-on: retained fields are left as they were (undefined)
    if (!aresetn) begin
      st_nxt.state    = rcsl_pkg::ST_HOLD;
      st_nxt.pin_sync = 3'h0;
      st_nxt.pin_lvl  = 1'b0;
      st_nxt.drt_cnt  = '0;
      st_nxt.core_rst = 1'b1;
      st_nxt.pc_low_byte      = rcsl_pkg::PCL_RST;
      st_nxt.dir      = rcsl_pkg::DIR_RST;
      st_nxt.opt      = rcsl_pkg::OPT_RST;
      st_nxt.status   = {rcsl_pkg::STS_PAGE_RST, rcsl_pkg::FL_POR, st_r.status[2:0]};
      st_nxt.ptr      = st_r.ptr | PTR_SET;
      st_nxt.evt      = 5'h01 << rcsl_pkg::EV_POR;
      st_nxt.mask     = 5'h00;
      st_nxt.irq      = 1'b0;
      st_nxt.aw_got   = 1'b0;
      st_nxt.aw_addr  = 8'h00;
      st_nxt.w_got    = 1'b0;
      st_nxt.w_data   = 8'h00;
      st_nxt.w_lane   = 1'b0;
      st_nxt.bvalid   = 1'b0;
      st_nxt.bresp    = rcsl_pkg::RESP_OKAY;
      st_nxt.rvalid   = 1'b0;
      st_nxt.rdata    = 8'h00;
      st_nxt.rresp    = rcsl_pkg::RESP_OKAY;
    end
    st_nxt.awready = aresetn && !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready  = aresetn && !st_nxt.w_got && !st_nxt.bvalid;
    st_nxt.arready = aresetn && !st_nxt.rvalid;
  end

  // state register
  always_ff @(posedge aclk) begin
    st_r <= st_nxt;
  end

  // outputs straight from the state register
  assign core_reset    = st_r.core_rst;
  assign irq           = st_r.irq;
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready  = st_r.wready;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rresp   = st_r.rresp;
  assign s_axi_rdata   = {24'h000000, st_r.rdata};

  logic run_r;
  assign run_r = (st_r.state == rcsl_pkg::ST_RUN);

  // checks on cause recording and reset values
  pin_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run_r && !st_r.pin_lvl && sleep_active |=> st_r.status[4:3] == 2'h2 && core_reset)
    else $error("pin wake flags wrong");
  pin_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run_r && !st_r.pin_lvl && !sleep_active |=> $stable(st_r.status[4:3]))
    else $error("pin run changed flags");
  wdt_run_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run_r && st_r.pin_lvl && wdt_timeout && !sleep_active
    |=> st_r.status[4:3] == 2'h1 && st_r.state == rcsl_pkg::ST_TIMING)
    else $error("watchdog run flags wrong");
  wdt_wake_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run_r && st_r.pin_lvl && wdt_timeout && sleep_active
    |=> st_r.status[4:3] == 2'h0 && core_reset)
    else $error("watchdog wake flags wrong");
  flags_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    core_reset && $past(core_reset) |-> $stable(st_r.status[4:3]))
    else $error("flags moved during reset");
  reset_vals_a: assert property (@(posedge aclk) disable iff (!aresetn)
    core_reset |-> st_r.pc_low_byte == 8'hff && st_r.dir == 8'hff && st_r.opt == 6'h3f)
    else $error("reset values not loaded");
  status_ptr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    core_reset |-> st_r.status[7:5] == 3'h0 && (st_r.ptr & PTR_SET) == PTR_SET)
    else $error("status or pointer top wrong");
  timer_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_r.state == rcsl_pkg::ST_HOLD && !st_r.pin_lvl |=> st_r.state == rcsl_pkg::ST_HOLD)
    else $error("timer ran with pin low");
  retain_a: assert property (@(posedge aclk) disable iff (!aresetn)
    run_r && !st_r.pin_lvl && !wr_en |=> $stable(st_r.acc) && $stable(st_r.second_port_latch))
    else $error("retained register changed");
  event_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ev_set != 5'h00 |=> ($past(ev_set) & ~st_r.evt) == 5'h00 && irq == |(st_r.evt & st_r.mask))
    else $error("cause event lost");
endmodule

//--- rcsl_partner.sv
// model of the external reset circuit and the on-chip watchdog
`timescale 1ns/1ps
module rcsl_partner (
  input  wire logic aclk,        // core clock
  input  wire logic hold_req,    // bench asks for the pin held low
  input  wire logic fire_req,    // bench asks for one watchdog time-out
  output logic      ext_reset_n, // reset pin, active low
  output logic      wdt_timeout  // watchdog time-out pulse
);
  // pin moves off the clock edge, like a real switch, to work the synchroniser
  initial ext_reset_n = 1'b1;
  always @(hold_req) ext_reset_n <= #1.3 !hold_req;
  // watchdog pulse lasts one core clock cycle
  initial wdt_timeout = 1'b0;
  always @(posedge aclk) wdt_timeout <= fire_req;
endmodule

//--- rcsl_bench.sv
// self-checking bench for the reset cause and state logic
`timescale 1ns/1ps
module rcsl_bench;
  localparam int RESET_DELAY_TIMER = 16;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        sleep_active = 1'b0;
  logic        hold_req = 1'b0;
  logic        fire_req = 1'b0;
  logic        ext_reset_n, wdt_timeout, core_reset, irq;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic [3:0]  strb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, fl, st;
  logic [31:0] v;
  logic [31:0] keep [9];
  int          err_total = 0, total_checks = 0, seed = 32'hf937c4b4, n, k, i;
  bit          pin, slp;

  // design under test and its far side
  rcsl_top #(.DRT_CYCLES(RESET_DELAY_TIMER), .SMALL_PTR(1'b0)) dut (.aclk, .aresetn, .ext_reset_n,
    .wdt_timeout, .sleep_active, .core_reset, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rcsl_partner partner (.aclk, .hold_req, .fire_req, .ext_reset_n, .wdt_timeout);

  // 200 mhz core clock
  always #2.5 aclk = ~aclk;

  // comparison, verdict and wait bound
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ok(input bit c);
    chk({31'h0, c}, 32'h1);
  endtask
  task automatic results();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic limit(input int c, input int m);
    if (c >= m) begin
      err_total++;
      results();
    end
  endtask

  // axi4-lite write, address and data offered together
  task automatic wr(input logic [5:0] idx, input logic [31:0] d, output logic [1:0] rs);
    bit da, dw, db, ta, tw;
    da = 0;
    dw = 0;
    db = 0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_wstrb <= strb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int c = 0; !db; c++) begin
      limit(c, 50);
      @(negedge aclk);
      ta = !da && s_axi_awready === 1'b1;
      tw = !dw && s_axi_wready === 1'b1;
      db = s_axi_bvalid === 1'b1;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      da = da | ta;
      dw = dw | tw;
    end
    s_axi_bready <= 1'b0;
  endtask
  // axi4-lite read
  task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] rs);
    bit ta, dr;
    ta = 0;
    dr = 0;
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int c = 0; !dr; c++) begin
      limit(c, 50);
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready === 1'b1;
      dr = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  // edges until the core leaves reset
  task automatic wait_free(output int c);
    for (c = 0; core_reset !== 1'b0; c++) begin
      limit(c, 400);
      @(posedge aclk);
      #1;
    end
  endtask

  // expected flag pair {timeout, powerdown} after a reset
  function automatic logic [1:0] exp_fl(bit p, bit s, logic [1:0] prev);
    if (p) return s ? 2'h2 : prev;
    return s ? 2'h0 : 2'h1;
  endfunction
  // expected cause event bit
  function automatic logic [31:0] exp_ev(bit p, bit s);
    return 32'h1 << (p ? (s ? 2 : 1) : (s ? 4 : 3));
  endfunction
  // expected read-back of a retained register
  function automatic logic [31:0] exp_keep(int idx, logic [31:0] d);
    if (idx == 5) return d & 32'h0f;
    if (idx == 4) return (d & 32'hff) | 32'h80;
    return d & 32'hff;
  endfunction

  // main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wait_free(n);
    ok(n >= RESET_DELAY_TIMER && n <= RESET_DELAY_TIMER + 8);
    rd(6'h3, v, r);
    chk(v & 32'hf8, 32'h18);
    rd(6'h2, v, r);
    chk(v, 32'hff);
    rd(6'h9, v, r);
    chk(v, 32'hff);
    rd(6'ha, v, r);
    chk(v, 32'h3f);
    rd(6'h4, v, r);
    chk(v & 32'h80, 32'h80);
    rd(6'hb, v, r);
    chk(v & 32'h1, 32'h1);
    wr(6'h3, 32'he7, r);
    rd(6'h3, v, r);
    chk(v & 32'h18, 32'h18);
    rd(6'he, v, r);
    chk({v[29:0], r}, {30'h0, rcsl_pkg::RESP_SLVERR});
    wr(6'he, 32'h5a, r);
    chk(32'(r), 32'(rcsl_pkg::RESP_SLVERR));
    wr(6'hc, 32'h1f, r);
    repeat (3) @(posedge aclk);
    #1 ok(irq === 1'b1);
    wr(6'hb, 32'h1f, r);
    repeat (3) @(posedge aclk);
    #1 ok(irq === 1'b0);
    fl = 2'h3;
    // causes: wdt run, pin run, pin wake, pin run, wdt wake
    for (k = 0; k < 5; k++) begin
      pin = k >= 1 && k <= 3;
      slp = k == 2 || k == 4;
      for (i = 0; i < 9; i++) begin
        if (i != 2 && i != 3) begin
          keep[i] = $random(seed);
          wr(i[5:0], keep[i], r);
        end
      end
      wr(6'h2, 32'h12, r);
      wr(6'h9, 32'h00, r);
      wr(6'ha, 32'h00, r);
      wr(6'h3, 32'he7, r);
      @(posedge aclk);
      sleep_active <= slp;
      if (pin) hold_req <= 1'b1;
      else fire_req <= 1'b1;
      @(posedge aclk);
      fire_req <= 1'b0;
      for (n = 0; core_reset !== 1'b1; n++) begin
        limit(n, 20);
        @(negedge aclk);
      end
      @(posedge aclk);
      sleep_active <= 1'b0;
      if (pin) begin
        rd(6'h3, v, r);
        st = v[4:3];
        repeat (10) @(posedge aclk);
        hold_req <= 1'b0;
        wait_free(n);
        ok(n >= RESET_DELAY_TIMER && n <= RESET_DELAY_TIMER + 8);
      end else begin
        wait_free(n);
        ok(n >= RESET_DELAY_TIMER - 1 && n <= RESET_DELAY_TIMER + 2);
      end
      fl = exp_fl(pin, slp, fl);
      rd(6'h3, v, r);
      chk(32'(v[4:3]), 32'(fl));
      chk(32'(v[7:5]), 32'h0);
      if (pin) chk(32'(st), 32'(fl));
      rd(6'h2, v, r);
      chk(v, 32'hff);
      rd(6'h9, v, r);
      chk(v, 32'hff);
      rd(6'ha, v, r);
      chk(v, 32'h3f);
      for (i = 0; i < 9; i++) begin
        if (i != 2 && i != 3) begin
          rd(i[5:0], v, r);
          chk(v, exp_keep(i, keep[i]));
        end
      end
      rd(6'hb, v, r);
      chk(v & 32'h1f, exp_ev(pin, slp));
      ok(irq === 1'b1);
      wr(6'hb, 32'h1f, r);
    end
    // low byte lane off: answer okay, register left alone
    strb = 4'he;
    wr(6'h8, ~keep[8], r);
    chk(32'(r), 32'(rcsl_pkg::RESP_OKAY));
    strb = 4'hf;
    rd(6'h8, v, r);
    chk(v, keep[8] & 32'hff);
    results();
  end
endmodule
